// ### include/pecpc_pkg.sv
// Purpose: Shared constants for the error counter and coding config block.
// Assumes: Registers sit one per 32-bit word, byte address = 4 * index.
// Notes: Indices stay as printed; the module scales them to bytes.
package pecpc_pkg;
    localparam int TALLY_W = 8;
    localparam int REG_W = 16;
    localparam logic [7:0] IDX_FALSE_CARRIER = 8'h14;
    localparam logic [7:0] IDX_RECEIVE_ERROR = 8'h15;
    localparam logic [7:0] IDX_CODING_CONFIG = 8'h16;
    localparam logic [1:0] WORD_SHIFT = 2'h2;
    localparam logic [TALLY_W-1:0] TALLY_MAX = 8'hFF;
    localparam logic [TALLY_W-1:0] TALLY_ONE = 8'h01;
    localparam logic [TALLY_W-1:0] TALLY_ZERO = 8'h00;
    localparam logic [REG_W-1:0] CFG_RESET = 16'h0100;
    localparam logic [REG_W-1:0] CFG_WMASK = 16'h1F27;
    localparam int CFG_BLOCK_CODE = 12;
    localparam int CFG_FREE_CLOCK = 11;
    localparam int CFG_TRUE_QUIET = 10;
    localparam int CFG_SD_FORCE = 9;
    localparam int CFG_SD_ALGO = 8;
    localparam int CFG_FORCE_100 = 5;
    localparam int CFG_NRZI = 2;
    localparam int CFG_SCRAMBLER = 1;
    localparam int CFG_DESCRAMBLER = 0;
    typedef enum logic {PECPC_IDLE, PECPC_IN_CARRIER} pecpc_carrier_t;
endpackage

// ### hdl/pecpc_regs.sv
// Purpose: False carrier and receive error tallies plus coding config bits.
// Assumes: Event inputs come from datapath logic on hclk, no synchroniser.
// Notes: AHB-Lite slave, zero wait states, always OKAY.
//
// Behaviour
// - Each false carrier event adds one to the 8-bit false carrier tally.
// - False carrier tally sticks at FFh instead of wrapping.
// - False carrier tally is writable, resets to zero, clears when read.
// - Receive error tally counts carriers holding at least one invalid symbol.
// - Receive error tally rises at most once per carrier event.
// - A carrier event with a collision never counts as receive error.
// - Receive error tally sticks at its maximum until cleared.
// - Receive error tally is writable, resets to zero, clears when read.
// - Reserved bits ignore writes and read as zero.
// - Config bit 12 skips the 4B5B block coder.
// - Config bit 11 lets the receive clock output run free.
// - Config bit 10 selects true quiet transmit at 100 Mb/s.
// - Config bit 9 forces signal detect asserted in the PMA.
// - Config bit 8, reset one, selects enhanced signal detect algorithm.
// - Config bit 5 forces 100 Mb/s link status good.
// - Config bit 2 skips NRZI encoding and decoding.
// - Config bit 1 skips the transmit scrambler.
// - Config bit 0 skips the receive descrambler.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
module pecpc_regs #(
    parameter int ADDR_W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hreadyin,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic false_carrier_event,
    input wire logic carrier_valid,
    input wire logic invalid_symbol,
    input wire logic collision,
    output logic block_code_skip,
    output logic receive_clock_free_run,
    output logic true_quiet_transmit_on,
    output logic signal_detect_override,
    output logic signal_detect_algorithm_select,
    output logic force_100_link_good,
    output logic nrzi_skip,
    output logic scrambler_skip,
    output logic descrambler_skip
);
    if (ADDR_W < 7) begin : g_bad_width
        $error("pecpc_regs: ADDR_W too small for the register map");
    end

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == pecpc_pkg::TALLY_MAX) ? v : v + pecpc_pkg::TALLY_ONE;
    endfunction

    function automatic logic hits(input logic [ADDR_W-1:0] a,
                                  input logic [7:0] idx);
        logic [ADDR_W-1:0] byte_addr;
        byte_addr = ADDR_W'(idx) << pecpc_pkg::WORD_SHIFT;
        hits = (a == byte_addr);
    endfunction

    logic [7:0] fc_reg;
    logic [7:0] fc_next;
    logic [7:0] rx_reg;
    logic [7:0] rx_next;
    logic [15:0] cfg_reg;
    logic [15:0] cfg_next;
    logic wr_pend_reg;
    logic [2:0] wr_sel_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    pecpc_pkg::pecpc_carrier_t carrier_reg;
    pecpc_pkg::pecpc_carrier_t carrier_next;
    logic err_seen_reg;
    logic err_seen_next;
    logic col_seen_reg;
    logic col_seen_next;

    wire addr_phase = hsel & htrans[1] & hreadyin;
    wire rd_acc = addr_phase & ~hwrite;
    wire wr_acc = addr_phase & hwrite;
    wire hit_fc = hits(haddr, pecpc_pkg::IDX_FALSE_CARRIER);
    wire hit_rx = hits(haddr, pecpc_pkg::IDX_RECEIVE_ERROR);
    wire hit_cfg = hits(haddr, pecpc_pkg::IDX_CODING_CONFIG);
    wire wr_fc = wr_pend_reg & wr_sel_reg[0];
    wire wr_rx = wr_pend_reg & wr_sel_reg[1];
    wire wr_cfg = wr_pend_reg & wr_sel_reg[2];
    wire clr_fc = rd_acc & hit_fc;
    wire clr_rx = rd_acc & hit_rx;

    // A write beats a clear, and an event in the same cycle still counts.
    wire [7:0] fc_base = wr_fc ? hwdata[7:0] :
        (clr_fc ? pecpc_pkg::TALLY_ZERO : fc_reg);
    assign fc_next = false_carrier_event ? sat_inc(fc_base) : fc_base;

    // The tally is judged when the carrier ends, because a collision may
    // show up late in the event and must still suppress the count.
    wire in_carrier = (carrier_reg == pecpc_pkg::PECPC_IN_CARRIER);
    wire carrier_end = in_carrier & ~carrier_valid;
    wire rx_inc = carrier_end & err_seen_reg & ~col_seen_reg;
    wire [7:0] rx_base = wr_rx ? hwdata[7:0] :
        (clr_rx ? pecpc_pkg::TALLY_ZERO : rx_reg);
    assign rx_next = rx_inc ? sat_inc(rx_base) : rx_base;

    assign cfg_next = wr_cfg ?
        (hwdata[15:0] & pecpc_pkg::CFG_WMASK) : cfg_reg;

    always_comb begin
        carrier_next = carrier_reg;
        err_seen_next = 1'b0;
        col_seen_next = 1'b0;
        unique case (carrier_reg)
            pecpc_pkg::PECPC_IDLE: begin
                if (carrier_valid) begin
                    carrier_next = pecpc_pkg::PECPC_IN_CARRIER;
                    err_seen_next = invalid_symbol;
                    col_seen_next = collision;
                end
            end
            pecpc_pkg::PECPC_IN_CARRIER: begin
                if (carrier_valid) begin
                    err_seen_next = err_seen_reg | invalid_symbol;
                    col_seen_next = col_seen_reg | collision;
                end else begin
                    carrier_next = pecpc_pkg::PECPC_IDLE;
                end
            end
        endcase
    end

    // Read data is the value before any clear or write in this same cycle.
    wire [15:0] rd_word = hit_fc ? {8'h00, fc_reg} :
        hit_rx ? {8'h00, rx_reg} :
        hit_cfg ? cfg_reg : 16'h0000;
    assign hrdata_next = rd_acc ? {16'h0000, rd_word} : 32'h00000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fc_reg <= pecpc_pkg::TALLY_ZERO;
            rx_reg <= pecpc_pkg::TALLY_ZERO;
            cfg_reg <= pecpc_pkg::CFG_RESET;
            wr_pend_reg <= 1'b0;
            wr_sel_reg <= 3'h0;
            hrdata_reg <= 32'h00000000;
            carrier_reg <= pecpc_pkg::PECPC_IDLE;
            err_seen_reg <= 1'b0;
            col_seen_reg <= 1'b0;
        end else begin
            fc_reg <= fc_next;
            rx_reg <= rx_next;
            cfg_reg <= cfg_next;
            wr_pend_reg <= wr_acc;
            wr_sel_reg <= {hit_cfg, hit_rx, hit_fc};
            hrdata_reg <= hrdata_next;
            carrier_reg <= carrier_next;
            err_seen_reg <= err_seen_next;
            col_seen_reg <= col_seen_next;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    assign hrdata = hrdata_reg;
    assign block_code_skip = cfg_reg[pecpc_pkg::CFG_BLOCK_CODE];
    assign receive_clock_free_run = cfg_reg[pecpc_pkg::CFG_FREE_CLOCK];
    assign true_quiet_transmit_on = cfg_reg[pecpc_pkg::CFG_TRUE_QUIET];
    assign signal_detect_override = cfg_reg[pecpc_pkg::CFG_SD_FORCE];
    assign signal_detect_algorithm_select =
        cfg_reg[pecpc_pkg::CFG_SD_ALGO];
    assign force_100_link_good = cfg_reg[pecpc_pkg::CFG_FORCE_100];
    assign nrzi_skip = cfg_reg[pecpc_pkg::CFG_NRZI];
    assign scrambler_skip = cfg_reg[pecpc_pkg::CFG_SCRAMBLER];
    assign descrambler_skip = cfg_reg[pecpc_pkg::CFG_DESCRAMBLER];

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    wire fc_quiet = ~wr_fc & ~clr_fc;
    wire rx_quiet = ~wr_rx & ~clr_rx;

    property p_fc_count;
        false_carrier_event && fc_quiet && fc_reg != 8'hFF
            |=> fc_reg == $past(fc_reg) + 8'h01;
    endproperty
    a_fc_count: assert property (p_fc_count)
        else $error("false carrier tally did not step by one");

    property p_fc_stick;
        fc_reg == 8'hFF && fc_quiet |=> fc_reg == 8'hFF;
    endproperty
    a_fc_stick: assert property (p_fc_stick)
        else $error("false carrier tally left its maximum");

    sequence s_fc_read;
        hsel && htrans[1] && hreadyin && !hwrite && hit_fc;
    endsequence
    property p_fc_clear;
        s_fc_read ##0 (!wr_fc && !false_carrier_event)
            |=> fc_reg == 8'h00 && hrdata[7:0] == $past(fc_reg);
    endproperty
    a_fc_clear: assert property (p_fc_clear)
        else $error("false carrier tally not returned and cleared on read");

    sequence s_bad_carrier;
        in_carrier && carrier_valid && !collision [*1] ##1
            !carrier_valid && err_seen_reg && !col_seen_reg;
    endsequence
    property p_rx_count;
        s_bad_carrier ##0 (rx_quiet && rx_reg != 8'hFF)
            |=> rx_reg == $past(rx_reg) + 8'h01;
    endproperty
    a_rx_count: assert property (p_rx_count)
        else $error("receive error tally missed a bad carrier");

    property p_rx_once;
        in_carrier && carrier_valid && rx_quiet |=> rx_reg == $past(rx_reg);
    endproperty
    a_rx_once: assert property (p_rx_once)
        else $error("receive error tally moved during a carrier");

    property p_rx_collision;
        carrier_end && col_seen_reg && rx_quiet |=> $stable(rx_reg);
    endproperty
    a_rx_collision: assert property (p_rx_collision)
        else $error("receive error tally counted a collided carrier");

    property p_rx_stick;
        rx_reg == 8'hFF && rx_quiet |=> rx_reg == 8'hFF;
    endproperty
    a_rx_stick: assert property (p_rx_stick)
        else $error("receive error tally left its maximum");

    property p_rx_clear;
        rd_acc && hit_rx && !wr_rx && !rx_inc |=> rx_reg == 8'h00;
    endproperty
    a_rx_clear: assert property (p_rx_clear)
        else $error("receive error tally not cleared on read");

    property p_reserved;
        (cfg_reg & ~pecpc_pkg::CFG_WMASK) == 16'h0000
            && hrdata[31:16] == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits not zero");

    property p_cfg_write;
        wr_cfg |=> {block_code_skip, receive_clock_free_run,
            true_quiet_transmit_on, signal_detect_override,
            signal_detect_algorithm_select, force_100_link_good,
            nrzi_skip, scrambler_skip, descrambler_skip}
            == {$past(hwdata[12:8]), $past(hwdata[5]), $past(hwdata[2:0])};
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("config outputs do not follow the written word");

    property p_load;
        wr_fc && !false_carrier_event |=> fc_reg == $past(hwdata[7:0]);
    endproperty
    a_load: assert property (p_load)
        else $error("written byte not loaded into false carrier tally");

    property p_fc_set_wins;
        s_fc_read ##0 (!wr_fc && false_carrier_event)
            |=> fc_reg == pecpc_pkg::TALLY_ONE;
    endproperty
    a_fc_set_wins: assert property (p_fc_set_wins)
        else $error("false carrier event lost to a clearing read");

    property p_fc_idle;
        !false_carrier_event && fc_quiet |=> $stable(fc_reg);
    endproperty
    a_fc_idle: assert property (p_fc_idle)
        else $error("false carrier tally moved with no event");

    property p_tally_upper;
        rd_acc && (hit_fc || hit_rx)
            |=> hrdata[15:8] == pecpc_pkg::TALLY_ZERO;
    endproperty
    a_tally_upper: assert property (p_tally_upper)
        else $error("reserved tally bits read back nonzero");

    property p_rx_read;
        rd_acc && hit_rx
            |=> hrdata[15:0] == {pecpc_pkg::TALLY_ZERO, $past(rx_reg)};
    endproperty
    a_rx_read: assert property (p_rx_read)
        else $error("receive error tally read back the wrong value");

    sequence s_carrier_open;
        !in_carrier && carrier_valid;
    endsequence
    property p_carrier_open;
        s_carrier_open |=> in_carrier
            && err_seen_reg == $past(invalid_symbol)
            && col_seen_reg == $past(collision);
    endproperty
    a_carrier_open: assert property (p_carrier_open)
        else $error("carrier start did not capture symbol or collision");

    property p_rx_load;
        wr_rx && !rx_inc |=> rx_reg == $past(hwdata[7:0]);
    endproperty
    a_rx_load: assert property (p_rx_load)
        else $error("written byte not loaded into receive error tally");

    // Checked on the first edge after release, before any bus transfer
    // can land, so a mid-run reset that misses a register shows here.
    property p_reset_values;
        $rose(hresetn) |-> cfg_reg == pecpc_pkg::CFG_RESET
            && fc_reg == pecpc_pkg::TALLY_ZERO
            && rx_reg == pecpc_pkg::TALLY_ZERO;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("registers not at reset values after release");

    property p_cfg_hold;
        !wr_cfg |=> $stable(cfg_reg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("config word changed without a write");

    property p_cfg_read;
        rd_acc && hit_cfg |=> hrdata[15:0] == $past(cfg_reg);
    endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("config word read back the wrong value");

    property p_free_clock;
        wr_cfg |=> receive_clock_free_run
            == $past(hwdata[pecpc_pkg::CFG_FREE_CLOCK]);
    endproperty
    a_free_clock: assert property (p_free_clock)
        else $error("receive clock mode bit not taken from the write");

    property p_true_quiet;
        wr_cfg |=> true_quiet_transmit_on
            == $past(hwdata[pecpc_pkg::CFG_TRUE_QUIET]);
    endproperty
    a_true_quiet: assert property (p_true_quiet)
        else $error("true quiet bit not taken from the write");

    property p_sd_force;
        wr_cfg |=> signal_detect_override
            == $past(hwdata[pecpc_pkg::CFG_SD_FORCE]);
    endproperty
    a_sd_force: assert property (p_sd_force)
        else $error("signal detect force bit not taken from the write");

    property p_sd_algo;
        wr_cfg |=> signal_detect_algorithm_select
            == $past(hwdata[pecpc_pkg::CFG_SD_ALGO]);
    endproperty
    a_sd_algo: assert property (p_sd_algo)
        else $error("signal detect algorithm bit not taken from the write");

    property p_nrzi;
        wr_cfg |=> nrzi_skip == $past(hwdata[pecpc_pkg::CFG_NRZI]);
    endproperty
    a_nrzi: assert property (p_nrzi)
        else $error("NRZI skip bit not taken from the write");

    property p_scrambler;
        wr_cfg |=> scrambler_skip
            == $past(hwdata[pecpc_pkg::CFG_SCRAMBLER]);
    endproperty
    a_scrambler: assert property (p_scrambler)
        else $error("scrambler skip bit not taken from the write");
endmodule

// ### tb/pecpc_mgmt_master.sv
// Purpose: AHB-Lite master that stands in for station management software.
// Assumes: One slave, whose hreadyout is the bus hready.
// Notes: Tasks are entered just after a rising edge of hclk.
`timescale 1ns/1ps
module pecpc_mgmt_master (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [7:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
    end
    task automatic addr_phase(input logic [7:0] a, input logic w);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_phase(a, 1'b1);
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        // Released data is inverted so no stale value looks held.
        hwdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        addr_phase(a, 1'b0);
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        d = hrdata;
    endtask
endmodule

// ### tb/tb_pecpc_regs.sv
// Purpose: Self-checking bench for the tallies and coding config register.
// Assumes: Zero wait state slave; event inputs are on hclk.
// Notes: Expected config values come from the package constants; tally values are literals.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_pecpc_regs;
    localparam logic [7:0] A_FC = pecpc_pkg::IDX_FALSE_CARRIER << 2;
    localparam logic [7:0] A_RE = pecpc_pkg::IDX_RECEIVE_ERROR << 2;
    localparam logic [7:0] A_CF = pecpc_pkg::IDX_CODING_CONFIG << 2;
    localparam logic [31:0] MASK = {16'h0000, pecpc_pkg::CFG_WMASK};
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, hready, hresp;
    logic false_carrier_event, carrier_valid, invalid_symbol, collision;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rdv, bit_v;
    wire logic [15:0] obs;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    assign obs[15:13] = 3'h0;
    assign obs[7:6] = 2'h0;
    assign obs[4:3] = 2'h0;
    always #5 hclk = ~hclk;
    pecpc_mgmt_master bus (.hclk(hclk), .hready(hready), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));
    pecpc_regs uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hreadyin(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp),
        .false_carrier_event(false_carrier_event),
        .carrier_valid(carrier_valid), .invalid_symbol(invalid_symbol),
        .collision(collision), .block_code_skip(obs[12]),
        .receive_clock_free_run(obs[11]),
        .true_quiet_transmit_on(obs[10]),
        .signal_detect_override(obs[9]),
        .signal_detect_algorithm_select(obs[8]),
        .force_100_link_good(obs[5]), .nrzi_skip(obs[2]),
        .scrambler_skip(obs[1]), .descrambler_skip(obs[0]));
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        bus.rd(a, rdv);
        `CHK(rdv, e)
    endtask
    task automatic fc_pulses(input int n);
        repeat (n) begin
            false_carrier_event <= 1'b1;
            @(posedge hclk);
        end
        false_carrier_event <= 1'b0;
        @(posedge hclk);
    endtask
    // A collision, when asked for, stands over the whole carrier.
    task automatic carrier(input int nsym, input logic col);
        carrier_valid <= 1'b1;
        collision <= col;
        @(posedge hclk);
        repeat (nsym) begin
            invalid_symbol <= 1'b1;
            @(posedge hclk);
        end
        invalid_symbol <= 1'b0;
        collision <= 1'b0;
        carrier_valid <= 1'b0;
        repeat (2) @(posedge hclk);
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        hresetn = 1'b0;
        false_carrier_event = 1'b0;
        carrier_valid = 1'b0;
        invalid_symbol = 1'b0;
        collision = 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        chk_rd(A_FC, 32'h00000000);
        chk_rd(A_RE, 32'h00000000);
        chk_rd(A_CF, {16'h0000, pecpc_pkg::CFG_RESET});
        `CHK(obs, pecpc_pkg::CFG_RESET)
        `CHK(hresp, 1'b0)
        `CHK(hready, 1'b1)
        fc_pulses(3);
        chk_rd(A_FC, 32'h00000003);
        chk_rd(A_FC, 32'h00000000);
        bus.wr(A_FC, 32'hFFFFFFFD);
        fc_pulses(1);
        chk_rd(A_FC, 32'h000000FE);
        bus.wr(A_FC, 32'h000000FD);
        fc_pulses(5);
        chk_rd(A_FC, 32'h000000FF);
        // An event in the same cycle as the clearing read still counts.
        fork
            fc_pulses(1);
            chk_rd(A_FC, 32'h00000000);
        join
        chk_rd(A_FC, 32'h00000001);
        carrier(3, 1'b0);
        carrier(1, 1'b1);
        carrier(0, 1'b0);
        chk_rd(A_RE, 32'h00000001);
        bus.wr(A_RE, 32'hFFFFFFFE);
        carrier(1, 1'b0);
        carrier(2, 1'b0);
        chk_rd(A_RE, 32'h000000FF);
        chk_rd(A_RE, 32'h00000000);
        for (int i = 0; i < 16; i++) begin
            bit_v = 32'h00000001 << i;
            bus.wr(A_CF, bit_v);
            chk_rd(A_CF, bit_v & MASK);
            `CHK(obs[12:8], bit_v[12:8])
            `CHK(obs[5], bit_v[5])
            `CHK(obs[2:0], bit_v[2:0])
            `CHK(obs, bit_v[15:0] & MASK[15:0])
        end
        bus.wr(A_CF, 32'hFFFFFFFF);
        chk_rd(A_CF, MASK);
        bus.wr(8'h5C, 32'hFFFFFFFF);
        chk_rd(8'h5C, 32'h00000000);
        // A reset in mid-run must bring back the reset values.
        fc_pulses(2);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        `CHK(obs, pecpc_pkg::CFG_RESET)
        `CHK(hready, 1'b1)
        chk_rd(A_FC, 32'h00000000);
        chk_rd(A_CF, {16'h0000, pecpc_pkg::CFG_RESET});
        results();
    end
endmodule
